// ---- hw/tms_sequencer.sv ----
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none
module tms_sequencer
  import tms_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger sources.
  input wire logic ext_trig,
  input wire logic key_trig,
  input wire logic bus_get,
  // Measurement side.
  output logic act_start,
  input wire logic act_done,
  input wire logic buf_has_data,
  output logic idle,
  output logic [7:0] scan_ptr
);
  tms_state_t q, d;

  function automatic logic [13:0] sat14(input logic [31:0] v, input logic [13:0] lo, input logic [13:0] hi);
    if (v < 32'(lo)) return lo;
    if (v > 32'(hi)) return hi;
    return v[13:0];
  endfunction

  logic wr_fire, rd_fire, src_event, bypass_cmd, abort_cmd, init_cmd, read_cmd;
  logic [31:0] imp_ohm;
  logic tmr_tick;

  assign s_axi_awready = !q.bus.aw && !q.bus.bvalid;
  assign s_axi_wready = !q.bus.w && !q.bus.bvalid;
  assign s_axi_arready = !q.bus.rvalid;
  assign s_axi_bvalid = q.bus.bvalid;
  assign s_axi_bresp = q.bus.bresp;
  assign s_axi_rvalid = q.bus.rvalid;
  assign s_axi_rdata = q.bus.rdata;
  assign s_axi_rresp = q.bus.rresp;
  assign wr_fire = q.bus.aw && q.bus.w && !q.bus.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign idle = (q.st == ST_IDLE);
  assign scan_ptr = q.scan_ptr;
  assign act_start = (q.st == ST_ACT);
  assign init_cmd = wr_fire && q.bus.awaddr == REG_CMD && q.bus.wdata[CMD_INIT];
  assign abort_cmd = wr_fire && q.bus.awaddr == REG_CMD && q.bus.wdata[CMD_ABORT];
  assign bypass_cmd = wr_fire && q.bus.awaddr == REG_CMD && q.bus.wdata[CMD_BYPASS];
  assign read_cmd = wr_fire && q.bus.awaddr == REG_CMD && q.bus.wdata[CMD_READ];
  assign imp_ohm = (q.bus.wdata + MILLI_HALF) / MILLI;
  assign tmr_tick = (q.cfg.src == SRC_TIMER) && q.tmr_ms >= q.cfg.timer_ms - 30'h1
                    && q.tmr_cyc == 15'(CYC_PER_MS - 1);

  always_comb begin
    unique case (q.cfg.src)
      SRC_IMM: src_event = 1'b1;
      SRC_EXT: src_event = ext_trig;
      SRC_TIMER: src_event = q.first_pass || q.tmr_pend;
      SRC_MANUAL: src_event = key_trig;
      SRC_BUS: src_event = bus_get || (wr_fire && q.bus.awaddr == REG_CMD && q.bus.wdata[CMD_BUSTRG]);
      default: src_event = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    if (s_axi_awvalid && s_axi_awready) begin
      d.bus.aw = 1'b1;
      d.bus.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.bus.w = 1'b1;
      d.bus.wdata = s_axi_wdata;
    end
    if (q.bus.bvalid && s_axi_bready) d.bus.bvalid = 1'b0;
    if (q.bus.rvalid && s_axi_rready) d.bus.rvalid = 1'b0;
    if (wr_fire) begin
      d.bus.aw = 1'b0;
      d.bus.w = 1'b0;
      d.bus.bvalid = 1'b1;
      d.bus.bresp = RESP_OKAY;
      unique case (q.bus.awaddr)
        REG_CTRL: begin
          d.cfg.cont = q.bus.wdata[CTRL_CONT];
          d.cfg.auto_dly = q.bus.wdata[CTRL_AUTO];
          if (q.bus.wdata[CTRL_SRC_LO +: 3] <= 3'(SRC_BUS)) d.cfg.src = tms_src_t'(q.bus.wdata[CTRL_SRC_LO +: 3]);
          else d.bus.bresp = RESP_SLVERR;
          if (q.bus.wdata[CTRL_CONT] && q.cfg.samp_cnt > SAMP_CNT_DEF) begin
            d.cfg.cont = 1'b0;
            d.bus.bresp = RESP_SLVERR;
          end
        end
        REG_CMD: ;
        REG_TRIG_CNT: begin
          if (q.bus.wdata == 32'h0) d.cfg.trig_cnt = UNBOUNDED_LOOP_COUNT;
          else if (q.bus.wdata <= 32'(TRIG_CNT_MAX)) d.cfg.trig_cnt = q.bus.wdata[13:0];
          else d.bus.bresp = RESP_SLVERR;
        end
        REG_DELAY_MS: begin
          if (q.bus.wdata <= 32'(DELAY_MS_MAX)) d.cfg.delay_ms = q.bus.wdata[29:0];
          else d.bus.bresp = RESP_SLVERR;
        end
        REG_TIMER_MS: begin
          if (q.bus.wdata >= 32'(TIMER_MS_MIN) && q.bus.wdata <= 32'(DELAY_MS_MAX)) begin
            d.cfg.timer_ms = q.bus.wdata[29:0];
          end else d.bus.bresp = RESP_SLVERR;
        end
        REG_SAMP_CNT: begin
          if (q.bus.wdata == 32'h0 || q.bus.wdata > 32'(SAMP_CNT_MAX)) d.bus.bresp = RESP_SLVERR;
          else if (q.cfg.cont && q.bus.wdata > 32'(SAMP_CNT_DEF)) d.bus.bresp = RESP_SLVERR;
          else d.cfg.samp_cnt = q.bus.wdata[10:0];
        end
        REG_UNITS: begin
          if (q.bus.wdata[1:0] != 2'h3) d.cfg.temp_u = tms_temp_t'(q.bus.wdata[1:0]);
          if (q.bus.wdata[5:4] != 2'h3) d.cfg.ac_u = tms_volt_t'(q.bus.wdata[5:4]);
          if (q.bus.wdata[9:8] != 2'h3) d.cfg.dc_u = tms_volt_t'(q.bus.wdata[9:8]);
        end
        REG_DB_REF: begin
          // Written in microvolts scaled by 1000 to nanovolts.
          if (40'(q.bus.wdata) * 40'(MILLI) < DBREF_MIN || 40'(q.bus.wdata) * 40'(MILLI) > DBREF_MAX)
            d.bus.bresp = RESP_SLVERR;
          else d.cfg.db_ref = 40'(q.bus.wdata) * 40'(MILLI);
        end
        REG_IMPED: d.cfg.imped = sat14(imp_ohm, IMPED_MIN, IMPED_MAX);
        default: d.bus.bresp = RESP_SLVERR;
      endcase
    end
    if (rd_fire) begin
      d.bus.rvalid = 1'b1;
      d.bus.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: d.bus.rdata = {25'h0, q.cfg.src, 2'h0, q.cfg.auto_dly, q.cfg.cont};
        REG_CMD: d.bus.rdata = 32'h0;
        REG_TRIG_CNT: d.bus.rdata = 32'(q.cfg.trig_cnt);
        REG_DELAY_MS: d.bus.rdata = 32'(q.cfg.delay_ms);
        REG_TIMER_MS: d.bus.rdata = 32'(q.cfg.timer_ms);
        REG_SAMP_CNT: d.bus.rdata = 32'(q.cfg.samp_cnt);
        REG_UNITS: d.bus.rdata = {22'h0, q.cfg.dc_u, 2'h0, q.cfg.ac_u, 2'h0, q.cfg.temp_u};
        REG_DB_REF: d.bus.rdata = 32'(q.cfg.db_ref / 40'(MILLI));
        REG_IMPED: d.bus.rdata = 32'(q.cfg.imped);
        REG_STATUS: d.bus.rdata = {24'h0, q.rd_rej, q.rd_ok, q.err, 2'h0, q.st};
        REG_SCAN: d.bus.rdata = 32'(q.scan_ptr);
        default: begin
          d.bus.rdata = 32'h0;
          d.bus.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Interval timer runs only while selected, counting milliseconds.
    if (q.cfg.src != SRC_TIMER || q.st == ST_IDLE) begin
      d.tmr_ms = '0;
      d.tmr_cyc = '0;
      d.tmr_pend = 1'b0;
    end else begin
      d.tmr_cyc = (q.tmr_cyc == 15'(CYC_PER_MS - 1)) ? 15'h0 : q.tmr_cyc + 15'h1;
      if (tmr_tick) d.tmr_ms = '0;
      else if (q.tmr_cyc == 15'(CYC_PER_MS - 1)) d.tmr_ms = q.tmr_ms + 30'h1;
      if (tmr_tick) d.tmr_pend = 1'b1;
    end

    if (read_cmd) begin
      d.rd_ok = !(q.cfg.cont || (q.cfg.samp_cnt > SAMP_CNT_DEF && buf_has_data));
      d.rd_rej = !d.rd_ok;
    end
    if (wr_fire && q.bus.awaddr == REG_CMD && q.bus.wdata[CMD_ERRCLR]) d.err = 1'b0;

    unique case (q.st)
      ST_IDLE: if (init_cmd || q.cfg.cont) d.st = ST_TOP;
      ST_TOP: begin
        d.loop_n = '0;
        d.first_pass = 1'b1;
        d.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (src_event || bypass_cmd) begin
          d.first_pass = 1'b0;
          if (q.cfg.src == SRC_TIMER && !q.first_pass) d.tmr_pend = tmr_tick;
          d.ms_n = '0;
          d.cyc_n = '0;
          d.samp_n = '0;
          d.st = (q.cfg.auto_dly && q.cfg.delay_ms != '0) ? ST_DELAY : ST_ACT;
        end
      end
      ST_DELAY: begin
        d.cyc_n = (q.cyc_n == 15'(CYC_PER_MS - 1)) ? 15'h0 : q.cyc_n + 15'h1;
        if (q.cyc_n == 15'(CYC_PER_MS - 1)) begin
          d.ms_n = q.ms_n + 30'h1;
          if (q.ms_n + 30'h1 >= q.cfg.delay_ms) d.st = ST_ACT;
        end
      end
      ST_ACT: d.st = ST_ACK;
      ST_ACK: begin
        if (act_done) begin
          if (q.samp_n + 11'h1 < q.cfg.samp_cnt) begin
            d.samp_n = q.samp_n + 11'h1;
            d.st = ST_ACT;
          end else if (q.cfg.trig_cnt == UNBOUNDED_LOOP_COUNT) begin
            d.st = ST_WAIT;
          end else if (q.loop_n + 14'h1 < q.cfg.trig_cnt) begin
            d.loop_n = q.loop_n + 14'h1;
            d.st = ST_WAIT;
          end else begin
            d.st = q.cfg.cont ? ST_TOP : ST_IDLE;
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
    if (bypass_cmd && q.st != ST_WAIT) d.err = 1'b1;
    if (abort_cmd) begin
      d.st = q.cfg.cont ? ST_TOP : ST_IDLE;
      d.scan_ptr = '0;
    end else if (q.st == ST_ACT) begin
      d.scan_ptr = q.scan_ptr + 8'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.cfg.trig_cnt <= TRIG_CNT_DEF;
      q.cfg.timer_ms <= TIMER_MS_DEF;
      q.cfg.samp_cnt <= SAMP_CNT_DEF;
      q.cfg.db_ref <= DBREF_DEF;
      q.cfg.imped <= IMPED_DEF;
      q.cfg.auto_dly <= 1'b1;
    end else begin
      q <= d;
    end
  end

  AST_IDLE_EXIT: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle && init_cmd && !abort_cmd) |=> q.st == ST_TOP) else $error("init did not leave idle");
  AST_CONT_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle && q.cfg.cont && !abort_cmd) |=> q.st == ST_TOP) else $error("continuous did not restart");
  AST_CONT_SAMP: assert property (@(posedge aclk) disable iff (!aresetn)
    q.cfg.cont |-> q.cfg.samp_cnt <= SAMP_CNT_DEF) else $error("sample count above one while continuous");
  AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_cmd |=> (q.st == ($past(q.cfg.cont) ? ST_TOP : ST_IDLE)) && q.scan_ptr == 8'h0)
    else $error("abort mishandled");
  AST_SCAN_RST: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_cmd |=> scan_ptr == 8'h0) else $error("scan pointer not reset");
  AST_TRIG_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
    q.cfg.trig_cnt <= TRIG_CNT_MAX) else $error("trigger count out of range");
  AST_EXT_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_WAIT && q.cfg.src == SRC_EXT && !ext_trig && !bypass_cmd && !abort_cmd) |=> q.st == ST_WAIT)
    else $error("left wait without external trigger");
  AST_IMM_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_WAIT && q.cfg.src == SRC_IMM && !abort_cmd) |=> q.st != ST_WAIT)
    else $error("immediate source waited");
  AST_NO_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_WAIT && !q.cfg.auto_dly) |=> q.st != ST_DELAY) else $error("delay while auto off");
  AST_BYPASS_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
    (bypass_cmd && q.st != ST_WAIT) |=> q.err) else $error("bypass error not flagged");
  AST_TMR_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    q.cfg.src != SRC_TIMER |=> !q.tmr_pend || q.cfg.src == SRC_TIMER) else $error("timer ran unselected");
  COV_DELAY: cover property (@(posedge aclk) q.st == ST_DELAY ##1 q.st == ST_ACT);
  COV_LOOP: cover property (@(posedge aclk) q.st == ST_ACK && act_done ##1 q.st == ST_WAIT);
  COV_ABORT: cover property (@(posedge aclk) abort_cmd && q.st == ST_WAIT);
endmodule
`default_nettype wire

// ---- shared/tms_pkg.sv ----
`default_nettype none
package tms_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_TRIG_CNT = 8'h08;
  localparam logic [7:0] REG_DELAY_MS = 8'h0c;
  localparam logic [7:0] REG_TIMER_MS = 8'h10;
  localparam logic [7:0] REG_SAMP_CNT = 8'h14;
  localparam logic [7:0] REG_UNITS = 8'h18;
  localparam logic [7:0] REG_DB_REF = 8'h1c;
  localparam logic [7:0] REG_IMPED = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_SCAN = 8'h28;
  // CTRL fields.
  localparam int CTRL_CONT = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_SRC_LO = 4;
  // CMD bits (write one to issue).
  localparam int CMD_INIT = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_BYPASS = 2;
  localparam int CMD_BUSTRG = 3;
  localparam int CMD_READ = 4;
  localparam int CMD_ERRCLR = 5;
  // Trigger count 0 encodes the unbounded loop count.
  localparam logic [13:0] TRIG_CNT_MAX = 14'h270f;
  localparam logic [13:0] TRIG_CNT_DEF = 14'h0001;
  localparam logic [13:0] UNBOUNDED_LOOP_COUNT = 14'h0000;
  localparam logic [10:0] SAMP_CNT_MAX = 11'h400;
  localparam logic [10:0] SAMP_CNT_DEF = 11'h001;
  localparam logic [29:0] DELAY_MS_MAX = 30'h3b9ac9ff;
  localparam logic [29:0] TIMER_MS_MIN = 30'h0000_0001;
  localparam logic [29:0] TIMER_MS_DEF = 30'h0000_0001;
  // dB reference in nanovolts, 100 to 1e12 (1e-7 V to 1000 V).
  localparam logic [39:0] DBREF_MIN = 40'h00_0000_0064;
  localparam logic [39:0] DBREF_MAX = 40'he8_d4a5_1000;
  localparam logic [39:0] DBREF_DEF = 40'h00_3b9a_ca00;
  // Impedance written in milliohms on the bus, held and read back in whole ohms.
  localparam logic [13:0] IMPED_MIN = 14'h0001;
  localparam logic [13:0] IMPED_MAX = 14'h270f;
  localparam logic [13:0] IMPED_DEF = 14'h0258;
  localparam logic [31:0] MILLI = 32'h0000_03e8;
  localparam logic [31:0] MILLI_HALF = 32'h0000_01f4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SRC_IMM = 3'b000, SRC_EXT = 3'b001, SRC_TIMER = 3'b010,
    SRC_MANUAL = 3'b011, SRC_BUS = 3'b100
  } tms_src_t;
  typedef enum logic [1:0] {TU_CEL = 2'b00, TU_FAR = 2'b01, TU_KEL = 2'b10} tms_temp_t;
  typedef enum logic [1:0] {VU_VOLT = 2'b00, VU_DB = 2'b01, DECIBEL_MILLIWATT_UNIT = 2'b10} tms_volt_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_TOP = 3'b001, ST_WAIT = 3'b010,
    ST_DELAY = 3'b011, ST_ACT = 3'b100, ST_ACK = 3'b101
  } tms_st_t;

  typedef struct packed {
    logic aw;
    logic w;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tms_bus_t;

  typedef struct packed {
    logic cont;
    logic auto_dly;
    tms_src_t src;
    logic [13:0] trig_cnt;
    logic [29:0] delay_ms;
    logic [29:0] timer_ms;
    logic [10:0] samp_cnt;
    tms_temp_t temp_u;
    tms_volt_t ac_u;
    tms_volt_t dc_u;
    logic [39:0] db_ref;
    logic [13:0] imped;
  } tms_cfg_t;

  typedef struct packed {
    tms_bus_t bus;
    tms_cfg_t cfg;
    tms_st_t st;
    logic [13:0] loop_n;
    logic [10:0] samp_n;
    logic [29:0] ms_n;
    logic [14:0] cyc_n;
    logic [29:0] tmr_ms;
    logic [14:0] tmr_cyc;
    logic tmr_pend;
    logic first_pass;
    logic err;
    logic rd_ok;
    logic rd_rej;
    logic [7:0] scan_ptr;
  } tms_state_t;
endpackage
`default_nettype wire

// ---- test/tms_meas_model.sv ----
`default_nettype none
module tms_meas_model #(
  parameter int LAT = 3
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Action handshake.
  input wire logic act_start,
  output logic act_done = 1'b0,
  // Buffer state.
  input wire logic buf_clr,
  output logic buf_has_data = 1'b0,
  output int n_act = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // Each action takes LAT cycles and leaves one reading in the buffer.
  always @(posedge aclk) begin
    act_done <= 1'b0;
    if (!aresetn) begin
      cnt <= 0;
      n_act <= 0;
      buf_has_data <= 1'b0;
    end else begin
      if (act_start) begin
        n_act <= n_act + 1;
        cnt <= LAT;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        act_done <= 1'b1;
        buf_has_data <= 1'b1;
      end
      if (buf_clr) begin
        buf_has_data <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/tms_sequencer_tb.sv ----
`default_nettype none
module tms_sequencer_tb;
  import tms_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic ext_trig = 1'b0;
  logic key_trig = 1'b0;
  logic bus_get = 1'b0;
  logic buf_clr = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, act_start, act_done, buf_has_data, idle;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d;
  logic [7:0] scan_ptr;
  int n_act, mismatches, check_count, cyc, base, dt, i, v;
  tms_src_t srcs[4] = '{SRC_EXT, SRC_MANUAL, SRC_BUS, SRC_BUS};

  always #25 aclk = ~aclk;

  tms_sequencer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_trig(ext_trig),
    .key_trig(key_trig), .bus_get(bus_get), .act_start(act_start), .act_done(act_done),
    .buf_has_data(buf_has_data), .idle(idle), .scan_ptr(scan_ptr));

  tms_meas_model mdl (.aclk(aclk), .aresetn(aresetn), .act_start(act_start), .act_done(act_done),
    .buf_clr(buf_clr), .buf_has_data(buf_has_data), .n_act(n_act));

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The whole run needs roughly 41000 cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok = aw_ok || (awready === 1'b1);
      w_ok = w_ok || (wready === 1'b1);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    dat = rdata;
    rsp = rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [1:0] rsp;
    rd(a, d, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    chk(d, e);
  endtask

  task automatic cmd(input int b);
    wr(REG_CMD, 32'h1 << b, RESP_OKAY);
  endtask

  task automatic ctrl(input logic cont, input logic auto_on, input tms_src_t s);
    wr(REG_CTRL, {25'h0, s, 2'b00, auto_on, cont}, RESP_OKAY);
  endtask

  task automatic stat_bit(input int b, input logic e);
    logic [1:0] rsp;
    rd(REG_STATUS, d, rsp);
    chk({31'h0, d[b]}, {31'h0, e});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (idle !== 1'b1 && n < 2000);
    chk({31'h0, idle}, 32'h1);
  endtask

  // Cycles from the call until the next device action begins.
  task automatic wait_act(output int t);
    int b;
    int t0;
    b = n_act;
    t0 = cyc;
    do @(posedge aclk); while (n_act == b && cyc - t0 < 30000);
    t = cyc - t0;
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, idle}, 32'h1);
    rdc(REG_TRIG_CNT, 32'h1);
    rdc(REG_SAMP_CNT, 32'h1);
    rdc(REG_DELAY_MS, 32'h0);
    rdc(REG_CTRL, 32'h2);
    rd(8'h2c, d, resp);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(REG_TRIG_CNT, 32'h2710, RESP_SLVERR);
    wr(REG_TRIG_CNT, 32'h270f, RESP_OKAY);
    rdc(REG_TRIG_CNT, 32'h270f);
    wr(REG_SAMP_CNT, 32'h401, RESP_SLVERR);
    wr(REG_SAMP_CNT, 32'h0, RESP_SLVERR);
    $display("test reset and limits done");
    ctrl(1'b0, 1'b0, SRC_IMM);
    wr(REG_TRIG_CNT, 32'h3, RESP_OKAY);
    wr(REG_SAMP_CNT, 32'h2, RESP_OKAY);
    base = n_act;
    cmd(CMD_INIT);
    wait_idle();
    chk(n_act - base, 32'h6);
    wr(REG_SAMP_CNT, 32'h1, RESP_OKAY);
    wr(REG_TRIG_CNT, 32'h1, RESP_OKAY);
    $display("test loop counts done");
    for (i = 0; i < 4; i++) begin
      ctrl(1'b0, 1'b0, srcs[i]);
      base = n_act;
      cmd(CMD_INIT);
      repeat (30) @(posedge aclk);
      chk(n_act - base, 32'h0);
      ext_trig <= (i == 0);
      key_trig <= (i == 1);
      bus_get <= (i == 2);
      if (i == 3) cmd(CMD_BUSTRG);
      wait_idle();
      ext_trig <= 1'b0;
      key_trig <= 1'b0;
      bus_get <= 1'b0;
      chk(n_act - base, 32'h1);
    end
    $display("test event sources done");
    cmd(CMD_BYPASS);
    stat_bit(5, 1'b1);
    cmd(CMD_ERRCLR);
    base = n_act;
    cmd(CMD_INIT);
    repeat (10) @(posedge aclk);
    cmd(CMD_BYPASS);
    wait_idle();
    chk(n_act - base, 32'h1);
    stat_bit(5, 1'b0);
    $display("test bypass done");
    ctrl(1'b0, 1'b1, SRC_IMM);
    wr(REG_DELAY_MS, 32'h1, RESP_OKAY);
    cmd(CMD_INIT);
    wait_act(dt);
    chk({31'h0, dt >= 19990 && dt <= 20030}, 32'h1);
    wait_idle();
    ctrl(1'b0, 1'b0, SRC_IMM);
    cmd(CMD_INIT);
    wait_act(dt);
    chk({31'h0, dt < 20}, 32'h1);
    wait_idle();
    $display("test delay done");
    ctrl(1'b0, 1'b0, SRC_TIMER);
    wr(REG_TIMER_MS, 32'h1, RESP_OKAY);
    wr(REG_TRIG_CNT, 32'h2, RESP_OKAY);
    cmd(CMD_INIT);
    wait_act(dt);
    chk({31'h0, dt < 20}, 32'h1);
    wait_act(dt);
    chk({31'h0, dt >= 19900 && dt <= 20100}, 32'h1);
    wait_idle();
    $display("test timer done");
    wr(REG_TRIG_CNT, 32'h1, RESP_OKAY);
    wr(REG_SAMP_CNT, 32'h2, RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_SLVERR);
    wr(REG_SAMP_CNT, 32'h1, RESP_OKAY);
    base = n_act;
    ctrl(1'b1, 1'b0, SRC_IMM);
    repeat (200) @(posedge aclk);
    chk({31'h0, n_act - base > 3}, 32'h1);
    cmd(CMD_READ);
    stat_bit(7, 1'b1);
    cmd(CMD_ABORT);
    repeat (5) @(posedge aclk);
    chk({31'h0, idle}, 32'h0);
    ctrl(1'b0, 1'b0, SRC_EXT);
    chk({31'h0, scan_ptr != 8'h0}, 32'h1);
    cmd(CMD_ABORT);
    wait_idle();
    chk({24'h0, scan_ptr}, 32'h0);
    $display("test continuous and abort done");
    ctrl(1'b0, 1'b0, SRC_IMM);
    wr(REG_SAMP_CNT, 32'h2, RESP_OKAY);
    cmd(CMD_INIT);
    wait_idle();
    cmd(CMD_READ);
    stat_bit(7, 1'b1);
    buf_clr <= 1'b1;
    @(posedge aclk);
    buf_clr <= 1'b0;
    cmd(CMD_READ);
    stat_bit(6, 1'b1);
    wr(REG_SAMP_CNT, 32'h1, RESP_OKAY);
    wr(REG_TRIG_CNT, {18'h0, UNBOUNDED_LOOP_COUNT}, RESP_OKAY);
    base = n_act;
    cmd(CMD_INIT);
    repeat (300) @(posedge aclk);
    chk({31'h0, idle}, 32'h0);
    chk({31'h0, n_act - base > 10}, 32'h1);
    cmd(CMD_ABORT);
    wait_idle();
    $display("test read query and unbounded done");
    for (i = 0; i < 3; i++) begin
      for (v = 0; v < 3; v++) begin
        wr(REG_UNITS, (i & 3) | ((v & 3) << 4) | (((2 - v) & 3) << 8), RESP_OKAY);
        rdc(REG_UNITS, (i & 3) | ((v & 3) << 4) | (((2 - v) & 3) << 8));
      end
    end
    wr(REG_DB_REF, 32'd100, RESP_OKAY);
    rdc(REG_DB_REF, 32'd100);
    wr(REG_DB_REF, 32'd0, RESP_SLVERR);
    wr(REG_DB_REF, 32'd1000000001, RESP_SLVERR);
    rdc(REG_DB_REF, 32'd100);
    wr(REG_IMPED, 32'd600500, RESP_OKAY);
    rdc(REG_IMPED, 32'd601);
    wr(REG_IMPED, 32'd1499, RESP_OKAY);
    rdc(REG_IMPED, 32'd1);
    $display("test units done");
    summarize();
  end
endmodule
`default_nettype wire
